// ===== verilog/llc_drive_pkg.sv
// shared constants and carrier types for the resonant drive sequencer
package llc_drive_pkg;

  // slow overcurrent must persist this many clock cycles
  localparam int SLOW_TRIP_CYCLES = 8;
  localparam int SLOW_CNT_W = 4;
  localparam logic [SLOW_CNT_W-1:0] SLOW_CNT_RST = 4'h0;

  // dead-time setting width and default
  localparam int DEAD_W = 6;
  localparam logic [DEAD_W-1:0] DEAD_RST = 6'h00;

  // half-period counter width, default half-period length and counter reset value
  localparam int HALF_W = 10;
  localparam logic [HALF_W-1:0] HALF_PERIOD_DEF = 10'h1F4;
  localparam logic [HALF_W-1:0] HALF_RST = 10'h000;

  // comparator levels arriving from the analog side
  typedef struct packed {
    logic fast_overcurrent_level;
    logic slow_overcurrent_level;
    logic freq_limit_hit;
    logic resonant_start_level;
    logic resonant_stop_level;
    logic boost_inhibit_level;
    logic soft_start_discharged;
  } comp_in_s;

  // gate drive outputs
  typedef struct packed {
    logic high_side_drive;
    logic low_side_drive;
    logic boost_gate_drive;
  } gate_out_s;

endpackage : llc_drive_pkg

// ===== verilog/dead_time_gen.sv
// shared dead-time generator: holds gap_active in each edge cycle and for dead_len cycles after it
`timescale 1ns/10ps
module dead_time_gen
  import llc_drive_pkg::*;
#(
  parameter int DW = DEAD_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // control
  input wire logic phase_edge,
  input wire logic [DW-1:0] dead_len,
  // status
  output logic gap_active
);

  logic [DW-1:0] gap_reg;
  logic [DW-1:0] gap_next;

  assign gap_next = phase_edge ? dead_len :
                    (gap_reg != '0) ? gap_reg - 1'b1 : gap_reg;
  assign gap_active = phase_edge || (gap_reg != '0);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gap_reg <= DW'(DEAD_RST);
    end else begin
      gap_reg <= gap_next;
    end
  end

endmodule : dead_time_gen

// ===== verilog/llc_drive_protection_sequencer.sv
// half-bridge and boost gate sequencer with overcurrent protection
// Contract
// R01: any resonant overcurrent fault turns both half-bridge drives off.
// R02: a fast overcurrent trip stops the resonant drive in the same cycle; the registered gate outputs drop one clock after the synchronised trip.
// R03: a slow overcurrent held for eight consecutive clocks stops the resonant drive.
// R04: a fast trip is also counted as a slow trip condition.
// R05: the two drives never overlap and have equal on-times each period.
// R06: each side runs at a nominal half of the switching period.
// R07: one dead-time generator times the gaps of both boost and resonant drives.
// R08: the dead-time length comes from the frequency-limit programming setting.
// R09: after supply start the boost gate switches while the resonant drives stay idle.
// R10: the start level enables the resonant drive and begins soft start.
// R11: at the frequency limit both resonant drives blank for whole clock cycles.
// R12: boost feedback below the stop level shuts the resonant drive down.
// R13: after a fault, restart waits for soft-start discharge and runs a new soft start.
// R14: boost switching is inhibited below the inhibit level.
// R15: a cycle without slow overcurrent clears the slow count.
// R16: drives resume only at a switching-period boundary after shutdown.
`timescale 1ns/10ps
module llc_drive_protection_sequencer
  import llc_drive_pkg::*;
#(
  parameter int HW = HALF_W,
  parameter int DW = DEAD_W,
  parameter logic [HALF_W-1:0] HALF_PERIOD = HALF_PERIOD_DEF
) (
  // clock and reset (reset follows supply lockout)
  input wire logic clk_sys,
  input wire logic resetn,
  // analog comparator results, asynchronous
  input wire llc_drive_pkg::comp_in_s comp_in,
  // dead-time setting from the frequency-limit programming input
  input wire logic [DW-1:0] freq_limit_program_input,
  // gate drives
  output llc_drive_pkg::gate_out_s gate_out,
  // status
  output logic soft_start_active,
  output logic resonant_fault
);
  import llc_drive_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  comp_in_s sync1_reg;
  comp_in_s sync2_reg;
  logic [DW-1:0] dead_sync1_reg;
  logic [DW-1:0] dead_sync2_reg;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      dead_sync1_reg <= DW'(DEAD_RST);
      dead_sync2_reg <= DW'(DEAD_RST);
    end else begin
      sync1_reg <= comp_in;
      sync2_reg <= sync1_reg;
      dead_sync1_reg <= freq_limit_program_input;
      dead_sync2_reg <= dead_sync1_reg;
    end
  end

  // ----------------------------------------------------------------
  // overcurrent detection
  // ----------------------------------------------------------------
  logic [SLOW_CNT_W-1:0] slow_cnt_reg;
  logic [SLOW_CNT_W-1:0] slow_cnt_next;
  wire fast_trip = sync2_reg.fast_overcurrent_level;
  wire slow_level = sync2_reg.slow_overcurrent_level || fast_trip; // R04
  // true once the slow count has reached its last step
  function automatic logic slow_count_full(input logic [SLOW_CNT_W-1:0] cnt);
    return cnt == SLOW_CNT_W'(SLOW_TRIP_CYCLES - 1);
  endfunction : slow_count_full

  wire slow_trip = slow_level && slow_count_full(slow_cnt_reg); // R03
  wire oc_fault = fast_trip || slow_trip; // R01

  assign slow_cnt_next = !slow_level ? SLOW_CNT_RST : // R15
                         slow_count_full(slow_cnt_reg) ? slow_cnt_reg :
                         slow_cnt_reg + 1'b1;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      slow_cnt_reg <= SLOW_CNT_RST;
    end else begin
      slow_cnt_reg <= slow_cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // start-up sequence
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_BOOST_ONLY, ST_SOFT_START, ST_RUN, ST_FAULT_WAIT} seq_e;
  seq_e seq_reg;
  seq_e seq_next;

  wire stop_low = !sync2_reg.resonant_stop_level; // R12
  wire resonant_kill = oc_fault || stop_low;
  logic period_end;

  always_comb begin
    seq_next = seq_reg;
    unique case (seq_reg)
      ST_BOOST_ONLY: begin
        if (sync2_reg.resonant_start_level && !stop_low && period_end) begin
          seq_next = ST_SOFT_START; // R10 R16
        end
      end
      ST_SOFT_START, ST_RUN: begin
        if (resonant_kill) begin
          seq_next = ST_FAULT_WAIT; // R02 R03 R12
        end else if (seq_reg == ST_SOFT_START && period_end) begin
          seq_next = ST_RUN;
        end
      end
      ST_FAULT_WAIT: begin
        if (sync2_reg.soft_start_discharged && !resonant_kill) begin
          seq_next = ST_BOOST_ONLY; // R13
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      seq_reg <= ST_BOOST_ONLY; // R09
    end else begin
      seq_reg <= seq_next;
    end
  end

  // ----------------------------------------------------------------
  // switching period and phase
  // ----------------------------------------------------------------
  logic [HW-1:0] half_cnt_reg;
  logic phase_reg;
  wire half_end = (half_cnt_reg == HALF_PERIOD - 1'b1);
  assign period_end = half_end && phase_reg;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      half_cnt_reg <= HW'(HALF_RST);
      phase_reg <= 1'b0;
    end else begin
      half_cnt_reg <= half_end ? HW'(HALF_RST) : half_cnt_reg + 1'b1; // R06
      phase_reg <= phase_reg ^ half_end; // R05
    end
  end

  // ----------------------------------------------------------------
  // shared dead time and drive outputs
  // ----------------------------------------------------------------
  logic gap_active;

  dead_time_gen #(
    .DW(DW)
  ) dead_time_gen_inst (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .phase_edge(half_end), // R07
    .dead_len(dead_sync2_reg), // R08
    .gap_active(gap_active)
  );

  wire resonant_on = (seq_reg == ST_SOFT_START || seq_reg == ST_RUN) && !resonant_kill;
  wire blank = sync2_reg.freq_limit_hit; // R11
  wire drive_ok = resonant_on && !blank && !gap_active;
  wire boost_ok = sync2_reg.boost_inhibit_level && !gap_active; // R14 R07
  gate_out_s gate_next;

  assign gate_next.high_side_drive = drive_ok && !phase_reg; // R05
  assign gate_next.low_side_drive = drive_ok && phase_reg; // R05
  assign gate_next.boost_gate_drive = boost_ok && !phase_reg; // R09

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gate_out <= '0;
      soft_start_active <= 1'b0;
      resonant_fault <= 1'b0;
    end else begin
      gate_out <= gate_next;
      soft_start_active <= (seq_next == ST_SOFT_START);
      resonant_fault <= (seq_next == ST_FAULT_WAIT);
    end
  end

  // ----------------------------------------------------------------
  // on-time bookkeeping for the symmetry check
  // ----------------------------------------------------------------
  logic [HW-1:0] on_cnt_reg;
  logic [HW-1:0] on_cnt_next;
  logic [HW-1:0] high_width_reg;
  logic clean_hi_reg;
  logic clean_cur_reg;
  // a half is only comparable when nothing cut its pulse or moved its gap
  wire pulse_upset = !resonant_on || blank || (dead_sync1_reg != dead_sync2_reg);
  wire side_on = gate_next.high_side_drive || gate_next.low_side_drive;

  assign on_cnt_next = half_end ? HW'(HALF_RST) : on_cnt_reg + HW'(side_on);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      on_cnt_reg <= HW'(HALF_RST);
      high_width_reg <= HW'(HALF_RST);
      clean_hi_reg <= 1'b0;
      clean_cur_reg <= 1'b0;
    end else begin
      on_cnt_reg <= on_cnt_next;
      if (half_end && !phase_reg) begin
        high_width_reg <= on_cnt_reg;
        clean_hi_reg <= clean_cur_reg && !pulse_upset;
      end
      clean_cur_reg <= half_end ? !pulse_upset : (clean_cur_reg && !pulse_upset);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence fast_seen;
    sync2_reg.fast_overcurrent_level;
  endsequence

  sequence slow_held;
    sync2_reg.slow_overcurrent_level [*8];
  endsequence

  property fast_off_p;
    @(posedge clk_sys) disable iff (!resetn)
      fast_seen |=> !gate_out.high_side_drive && !gate_out.low_side_drive;
  endproperty

  property slow_off_p;
    @(posedge clk_sys) disable iff (!resetn)
      slow_held |=> !gate_out.high_side_drive && !gate_out.low_side_drive;
  endproperty

  sequence restart_step;
    seq_reg == ST_BOOST_ONLY && seq_next == ST_SOFT_START;
  endsequence

  fast_shutdown_a: assert property (fast_off_p) else $error("drive on after fast trip"); // R02
  slow_shutdown_a: assert property (slow_off_p) else $error("drive on after slow trip"); // R03
  no_overlap_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R05
    !(gate_out.high_side_drive && gate_out.low_side_drive))
    else $error("drives overlap");
  fault_both_off_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R01
    oc_fault |=> !gate_out.high_side_drive && !gate_out.low_side_drive)
    else $error("drive on during fault");
  slow_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R15
    !slow_level |=> slow_cnt_reg == SLOW_CNT_RST)
    else $error("slow count not cleared");
  fast_counted_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R04
    fast_trip |=> slow_cnt_reg != SLOW_CNT_RST)
    else $error("fast trip not counted");
  blank_limit_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R11
    blank |=> !gate_out.high_side_drive && !gate_out.low_side_drive)
    else $error("drive on at frequency limit");
  boost_inhibit_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R14
    !sync2_reg.boost_inhibit_level |=> !gate_out.boost_gate_drive)
    else $error("boost gate while inhibited");
  stop_level_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R12
    stop_low |=> seq_reg == ST_FAULT_WAIT || seq_reg == ST_BOOST_ONLY)
    else $error("resonant stage on below stop level");
  idle_at_start_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R09
    seq_reg == ST_BOOST_ONLY |=> !gate_out.high_side_drive && !gate_out.low_side_drive)
    else $error("resonant drive before enable");
  dead_gap_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R07
    half_end |=> !gate_out.high_side_drive && !gate_out.low_side_drive
      && !gate_out.boost_gate_drive)
    else $error("no dead time at edge");
  restart_boundary_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R16
    restart_step |-> period_end)
    else $error("restart off boundary");
  soft_after_start_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R10
    restart_step |=> soft_start_active)
    else $error("soft start not flagged");
  restart_discharge_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R13
    (seq_reg == ST_FAULT_WAIT && !sync2_reg.soft_start_discharged) |=>
      seq_reg == ST_FAULT_WAIT)
    else $error("restart before discharge");
  dead_setting_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R08
    half_end |=> dead_time_gen_inst.gap_reg == $past(dead_sync2_reg))
    else $error("dead time not from setting");
  half_toggle_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R06
    half_end |=> half_cnt_reg == HW'(HALF_RST) && phase_reg != $past(phase_reg))
    else $error("half period not restarted");
  soft_to_run_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R10
    (seq_reg == ST_SOFT_START && !resonant_kill && period_end) |=> seq_reg == ST_RUN)
    else $error("soft start did not end");
  fault_flag_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R01
    (oc_fault && (seq_reg == ST_SOFT_START || seq_reg == ST_RUN)) |=> resonant_fault)
    else $error("fault not flagged");
  boost_phase_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R07
    gate_out.boost_gate_drive |-> !gate_out.low_side_drive)
    else $error("boost gate in low-side phase");
  equal_on_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R05
    (half_end && phase_reg && clean_hi_reg && clean_cur_reg && !pulse_upset) |->
      on_cnt_reg == high_width_reg)
    else $error("unequal on-times");

endmodule : llc_drive_protection_sequencer

// ===== verif/llc_bridge_model.sv
// far-side model: analog comparator levels and half-bridge overlap watch
`timescale 1ns/10ps
module llc_bridge_model
  import llc_drive_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // wanted analog state and gate drives
  input wire llc_drive_pkg::comp_in_s req,
  input wire llc_drive_pkg::gate_out_s gate_out,
  // comparator levels and bridge status
  output llc_drive_pkg::comp_in_s comp_in,
  output logic overlap_seen
);
  // -----------------------------------------
  // comparators
  // -----------------------------------------
  always_comb begin
    comp_in = req;
    // the fast level sits above the slow one
    comp_in.slow_overcurrent_level = req.slow_overcurrent_level | req.fast_overcurrent_level;
  end
  initial overlap_seen = 1'b0;
  always @(posedge clk_sys) begin
    if (gate_out.high_side_drive && gate_out.low_side_drive) begin
      overlap_seen <= 1'b1;
    end
  end
endmodule : llc_bridge_model

// ===== verif/tb_llc_drive_protection_sequencer.sv
// self-checking bench for the resonant drive sequencer
`timescale 1ns/10ps
module tb_llc_drive_protection_sequencer;
  import llc_drive_pkg::*;
  // half period matches the HALF_PERIOD override below
  localparam int HP = 16;
  localparam int DL = 3;
  localparam int DL2 = 5;
  localparam int ON = HP - DL - 1;
  logic clk_sys;
  logic resetn;
  comp_in_s req;
  comp_in_s comp_in;
  logic [DEAD_W-1:0] freq_limit_program_input;
  gate_out_s gate_out;
  logic soft_start_active;
  logic resonant_fault;
  logic overlap_seen;
  int fails;
  int checks;
  int hs;
  int ls;
  int bo;
  llc_drive_protection_sequencer #(.HALF_PERIOD(10'h010)) llc_drive_protection_sequencer_inst (
    .clk_sys(clk_sys), .resetn(resetn), .comp_in(comp_in),
    .freq_limit_program_input(freq_limit_program_input), .gate_out(gate_out),
    .soft_start_active(soft_start_active), .resonant_fault(resonant_fault));
  llc_bridge_model llc_bridge_model_inst (.clk_sys(clk_sys), .req(req), .gate_out(gate_out),
    .comp_in(comp_in), .overlap_seen(overlap_seen));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // -----------------------------------------
  // helpers
  // -----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  task automatic count(input int n);
    hs = 0;
    ls = 0;
    bo = 0;
    repeat (n) begin
      @(negedge clk_sys);
      hs += int'(gate_out.high_side_drive);
      ls += int'(gate_out.low_side_drive);
      bo += int'(gate_out.boost_gate_drive);
    end
  endtask : count
  task automatic wait_hs(input int lim);
    int n;
    n = 0;
    while (gate_out.high_side_drive !== 1'b1 && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
  endtask : wait_hs
  task automatic give_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  // -----------------------------------------
  // scenarios
  // -----------------------------------------
  task automatic t_start;
    count(4 * HP);
    check("boost pulses", 16'(bo > 0), 16'h0001);
    check("bridge idle", 16'(hs + ls), 16'h0000);
    req.resonant_start_level = 1'b1;
    wait_hs(8 * HP);
    check("started", 16'(gate_out.high_side_drive), 16'h0001);
    check("soft start", 16'(soft_start_active), 16'h0001);
    cyc(4 * HP);
    count(2 * HP);
    check("high on", 16'(hs), 16'(ON));
    check("low on", 16'(ls), 16'(ON));
    check("boost on", 16'(bo), 16'(ON));
    check("soft start over", 16'(soft_start_active), 16'h0000);
    check("overlap", 16'(overlap_seen), 16'h0000);
  endtask : t_start
  task automatic t_fast;
    wait_hs(4 * HP);
    req.fast_overcurrent_level = 1'b1;
    cyc(3);
    check("fast off", 16'(gate_out.high_side_drive | gate_out.low_side_drive), 16'h0000);
    req.fast_overcurrent_level = 1'b0;
    count(4 * HP);
    check("held off", 16'(hs + ls), 16'h0000);
    check("fault", 16'(resonant_fault), 16'h0001);
    req.soft_start_discharged = 1'b1;
    wait_hs(8 * HP);
    check("restart", 16'(gate_out.high_side_drive), 16'h0001);
    req.soft_start_discharged = 1'b0;
    hs = 0;
    while (gate_out.high_side_drive === 1'b1 && hs < HP) begin
      @(negedge clk_sys);
      hs++;
    end
    check("first pulse", 16'(hs), 16'(ON));
  endtask : t_fast
  task automatic t_slow;
    req.slow_overcurrent_level = 1'b1;
    cyc(7);
    req.slow_overcurrent_level = 1'b0;
    cyc(1);
    req.slow_overcurrent_level = 1'b1;
    cyc(7);
    req.slow_overcurrent_level = 1'b0;
    cyc(6);
    check("seven slow", 16'(resonant_fault), 16'h0000);
    req.slow_overcurrent_level = 1'b1;
    cyc(8);
    req.slow_overcurrent_level = 1'b0;
    cyc(4);
    check("eight slow", 16'(resonant_fault), 16'h0001);
    check("slow off", 16'(gate_out.high_side_drive | gate_out.low_side_drive), 16'h0000);
    req.soft_start_discharged = 1'b1;
    wait_hs(8 * HP);
    check("slow restart", 16'(gate_out.high_side_drive), 16'h0001);
    req.soft_start_discharged = 1'b0;
  endtask : t_slow
  task automatic t_limits;
    req.freq_limit_hit = 1'b1;
    cyc(3);
    count(2 * HP);
    check("blanked", 16'(hs + ls), 16'h0000);
    req.freq_limit_hit = 1'b0;
    wait_hs(4 * HP);
    check("unblanked", 16'(gate_out.high_side_drive), 16'h0001);
    freq_limit_program_input = 6'(DL2);
    cyc(4 * HP);
    count(2 * HP);
    check("high on new dead", 16'(hs), 16'(HP - DL2 - 1));
    check("low on new dead", 16'(ls), 16'(HP - DL2 - 1));
    req.resonant_stop_level = 1'b0;
    req.resonant_start_level = 1'b0;
    cyc(3);
    count(2 * HP);
    check("stopped", 16'(hs + ls), 16'h0000);
    req.boost_inhibit_level = 1'b0;
    cyc(3);
    count(2 * HP);
    check("inhibited", 16'(bo), 16'h0000);
  endtask : t_limits
  // -----------------------------------------
  // main sequence and watchdog
  // -----------------------------------------
  initial begin
    fails = 0;
    checks = 0;
    resetn = 1'b0;
    req = '0;
    req.resonant_stop_level = 1'b1;
    req.boost_inhibit_level = 1'b1;
    freq_limit_program_input = 6'(DL);
    cyc(4);
    check("reset gates", 16'(gate_out), 16'h0000);
    resetn = 1'b1;
    t_start();
    t_fast();
    t_slow();
    t_limits();
    give_verdict();
  end
  initial begin
    #100000;
    fails++;
    give_verdict();
  end
endmodule : tb_llc_drive_protection_sequencer
